// ===== logic/abbe_branch_unit.v
/*
  branch evaluator: decides whether a relative branch is taken and
  computes its target as pc + 2 + 2n.
  assumes the instruction word and flags are stable during the cycle.
*/
`timescale 1ns/1ps
`include "abbe_consts.vh"

module abbe_branch_unit #(
  parameter PC_W = 21
) (
  // instruction and state
  input wire [15:0] instr,
  input wire [PC_W-1:0] pc_cur,
  input wire [4:0] flags,
  // decision
  output reg is_branch,
  output reg taken,
  output wire [PC_W-1:0] target
);

  wire [7:0] op_hi;
  wire [PC_W-1:0] offs2;

  assign op_hi = instr[`ABBE_OP_BR_HI:`ABBE_OP_BR_LO];
  // twice the sign-extended offset
  assign offs2 = {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0};
  // target counts from the already incremented counter
  assign target = pc_cur + `ABBE_PC_STEP + offs2;

  // condition select per branch opcode
  always @* begin
    is_branch = 1'b1;
    taken = 1'b0;
    case (op_hi)
      `ABBE_OP_BC: taken = flags[`ABBE_FLG_C];
      `ABBE_OP_BNC: taken = ~flags[`ABBE_FLG_C];
      `ABBE_OP_BN: taken = flags[`ABBE_FLG_N];
      `ABBE_OP_BNN: taken = ~flags[`ABBE_FLG_N];
      `ABBE_OP_BRANCH_ON_NO_OVERFLOW: taken = ~flags[`ABBE_FLG_OV];
      default: is_branch = 1'b0;
    endcase
  end

endmodule

// ===== logic/abbe_consts.vh
/*
  constants for the and / bit-clear / branch execution block:
  opcode patterns, field positions, flag positions, phase codes.
  assumes inclusion by bare name from the design files.
*/
`ifndef ABBE_CONSTS_VH
`define ABBE_CONSTS_VH

// opcode patterns and field slices of the 16-bit instruction word
`define ABBE_OP_AND_WREG_WITH_FILE_HI 15
`define ABBE_OP_AND_WREG_WITH_FILE_LO 10
`define ABBE_OP_AND_WREG_WITH_FILE 6'h05
`define ABBE_OP_BCLR_HI 15
`define ABBE_OP_BCLR_LO 12
`define ABBE_OP_BCLR 4'h9
`define ABBE_OP_BR_HI 15
`define ABBE_OP_BR_LO 8
`define ABBE_OP_BC 8'hE2
`define ABBE_OP_BNC 8'hE3
`define ABBE_OP_BN 8'h6E
`define ABBE_OP_BNN 8'hE7
`define ABBE_OP_BRANCH_ON_NO_OVERFLOW 8'hE5
`define ABBE_DEST_BIT 9
`define ABBE_ACC_BIT 8
`define ABBE_BIDX_HI 11
`define ABBE_BIDX_LO 9
`define ABBE_FADDR_HI 7
`define ABBE_FADDR_LO 0

// indexed literal offset limit on the file address
`define ABBE_ILO_LIMIT 8'h5F

// status flag positions in the five-bit flag vector {n, ov, z, dc, c}
`define ABBE_FLG_C 0
`define ABBE_FLG_DC 1
`define ABBE_FLG_Z 2
`define ABBE_FLG_OV 3
`define ABBE_FLG_N 4
`define ABBE_NEG_BIT 7

// quarter phases of one instruction cycle
`define ABBE_PH_Q1 2'h0
`define ABBE_PH_Q2 2'h1
`define ABBE_PH_Q3 2'h2
`define ABBE_PH_Q4 2'h3

// program counter step per instruction word
`define ABBE_PC_STEP 21'h000002

// reset values
`define ABBE_WREG_RST 8'h00
`define ABBE_FLAGS_RST 5'h00

`endif

// ===== logic/abbe_exec.v
/*
  executes and_wreg_with_file, clear_file_bit and five conditional
  branches over a four-phase instruction cycle.
  assumes the fetch unit presents instr and pc when instr_valid is high
  at q1 and holds them for the cycle; file memory read data returns
  in the same clock as mem_rd_en; flags come in and are driven back here.
*/
`timescale 1ns/1ps
`include "abbe_consts.vh"

module abbe_exec #(
  parameter PC_W = 21
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // fetch side
  input wire instr_valid,
  input wire [15:0] instr,
  input wire [PC_W-1:0] pc_cur,
  // configuration
  input wire ext_set_en,
  input wire [3:0] bank_select_register,
  input wire [4:0] flags_in,
  // data memory
  input wire [7:0] mem_rd_data,
  output reg mem_rd_en_q,
  output reg mem_wr_en_q,
  output reg [11:0] mem_addr_q,
  output reg [7:0] mem_wr_data_q,
  output reg ilo_mode_q,
  // results
  output reg [7:0] wreg_q,
  output reg [4:0] flags_q,
  output reg flags_wr_q,
  output reg pc_load_q,
  output reg [PC_W-1:0] pc_target_q,
  output reg flush_q,
  output reg busy_q,
  output reg [1:0] phase_out_q,
  output reg illegal_q
);

  // operation kinds
  localparam OP_NONE = 2'h0;
  localparam OP_AND = 2'h1;
  localparam OP_BCLR = 2'h2;
  localparam OP_BR = 2'h3;

  // four-phase sequencing
  wire [1:0] phase;
  wire last;
  // branch evaluation
  wire br_is;
  wire br_taken;
  wire [PC_W-1:0] br_target;
  // latched decode
  reg [1:0] op_q;
  reg [1:0] op_d;
  reg [15:0] ins_q;
  reg [7:0] opnd_q; // operand captured in q3
  reg [7:0] res_q; // result computed in q3
  reg taken_q; // branch taken, used for the nop cycle
  reg nop_cycle_q; // second cycle of a taken branch
  reg [PC_W-1:0] tgt_q;

  abbe_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .phase_q(phase),
    .last_q(last)
  );

  abbe_branch_unit #(.PC_W(PC_W)) u_br (
    .instr(instr),
    .pc_cur(pc_cur),
    .flags(flags_in),
    .is_branch(br_is),
    .taken(br_taken),
    .target(br_target)
  );

  // builds the data address from bank bit, bank register and file address
  function [11:0] file_addr;
    input [15:0] iw;
    input [3:0] bank;
    begin
      if (iw[`ABBE_ACC_BIT])
        file_addr = {bank, iw[`ABBE_FADDR_HI:`ABBE_FADDR_LO]};
      else if (iw[`ABBE_FADDR_HI:`ABBE_FADDR_LO] > `ABBE_ILO_LIMIT)
        file_addr = {4'hF, iw[`ABBE_FADDR_HI:`ABBE_FADDR_LO]};
      else
        file_addr = {4'h0, iw[`ABBE_FADDR_HI:`ABBE_FADDR_LO]};
    end
  endfunction

  // tells whether the operand uses indexed literal offset addressing
  function ilo_sel;
    input [15:0] iw;
    input ext;
    begin
      ilo_sel = ext && !iw[`ABBE_ACC_BIT] &&
        (iw[`ABBE_FADDR_HI:`ABBE_FADDR_LO] <= `ABBE_ILO_LIMIT);
    end
  endfunction

  // opcode decode of the incoming word
  always @* begin
    if (instr[`ABBE_OP_AND_WREG_WITH_FILE_HI:`ABBE_OP_AND_WREG_WITH_FILE_LO] == `ABBE_OP_AND_WREG_WITH_FILE)
      op_d = OP_AND;
    else if (instr[`ABBE_OP_BCLR_HI:`ABBE_OP_BCLR_LO] == `ABBE_OP_BCLR)
      op_d = OP_BCLR;
    else if (br_is)
      op_d = OP_BR;
    else
      op_d = OP_NONE;
  end

  // phase sequencer: q1 decode, q2 read, q3 compute, q4 write
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= OP_NONE;
      ins_q <= 16'h0000;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      taken_q <= 1'b0;
      nop_cycle_q <= 1'b0;
      tgt_q <= {PC_W{1'b0}};
      wreg_q <= `ABBE_WREG_RST;
      flags_q <= `ABBE_FLAGS_RST;
      flags_wr_q <= 1'b0;
      mem_rd_en_q <= 1'b0;
      mem_wr_en_q <= 1'b0;
      mem_addr_q <= 12'h000;
      mem_wr_data_q <= 8'h00;
      ilo_mode_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_target_q <= {PC_W{1'b0}};
      flush_q <= 1'b0;
      busy_q <= 1'b0;
      phase_out_q <= `ABBE_PH_Q1;
      illegal_q <= 1'b0;
    end else begin
      // strobes last one clock
      flags_wr_q <= 1'b0;
      mem_rd_en_q <= 1'b0;
      mem_wr_en_q <= 1'b0;
      pc_load_q <= 1'b0;
      phase_out_q <= phase;
      case (phase)
        `ABBE_PH_Q1: begin
          // decode; a taken branch's second cycle decodes nothing
          if (nop_cycle_q) begin
            op_q <= OP_NONE;
            busy_q <= 1'b1;
            illegal_q <= 1'b0;
          end else begin
            op_q <= instr_valid ? op_d : OP_NONE;
            ins_q <= instr;
            taken_q <= br_taken & br_is;
            tgt_q <= br_target;
            busy_q <= instr_valid;
            illegal_q <= instr_valid && (op_d == OP_NONE);
            mem_addr_q <= file_addr(instr, bank_select_register);
            ilo_mode_q <= ilo_sel(instr, ext_set_en);
          end
        end
        `ABBE_PH_Q2: begin
          // operand read request for file instructions
          if (op_q == OP_AND || op_q == OP_BCLR)
            mem_rd_en_q <= 1'b1;
        end
        `ABBE_PH_Q3: begin
          // compute using returned operand
          opnd_q <= mem_rd_data;
          if (op_q == OP_AND)
            res_q <= wreg_q & mem_rd_data;
          else if (op_q == OP_BCLR)
            res_q <= mem_rd_data & ~(8'h01 << ins_q[`ABBE_BIDX_HI:`ABBE_BIDX_LO]);
          else
            res_q <= 8'h00;
        end
        default: begin
          // q4: write destination, load pc, update flags
          nop_cycle_q <= 1'b0;
          flush_q <= 1'b0;
          if (op_q == OP_AND) begin
            if (ins_q[`ABBE_DEST_BIT]) begin
              mem_wr_en_q <= 1'b1;
              mem_wr_data_q <= res_q;
            end else begin
              wreg_q <= res_q;
            end
            // only n and z change; c, dc, ov pass through
            flags_q <= flags_in;
            flags_q[`ABBE_FLG_Z] <= (res_q == 8'h00);
            flags_q[`ABBE_FLG_N] <= res_q[`ABBE_NEG_BIT];
            flags_wr_q <= 1'b1;
          end else if (op_q == OP_BCLR) begin
            mem_wr_en_q <= 1'b1;
            mem_wr_data_q <= res_q;
          end else if (op_q == OP_BR && taken_q) begin
            // branches leave flags alone
            pc_load_q <= 1'b1;
            pc_target_q <= tgt_q;
            nop_cycle_q <= 1'b1;
            flush_q <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// ===== logic/abbe_phase_gen.v
/*
  four-phase generator: walks q1..q4 and marks the last phase.
  assumes one free-running clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "abbe_consts.vh"

module abbe_phase_gen (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // phase outputs
  output reg [1:0] phase_q,
  output reg last_q
);

  // phase counter; wraps after q4
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= `ABBE_PH_Q1;
      last_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      last_q <= (phase_q == `ABBE_PH_Q3);
    end
  end

endmodule

// ===== verif/abbe_exec_props.sv
/* checker for the execution block: addressing, timing and results.
   assumes a bind onto the block's top module. */
`timescale 1ns/1ps
module abbe_exec_props (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // watched inputs
  input wire [15:0] instr,
  input wire ext_set_en,
  input wire [3:0] bank_select_register,
  input wire [4:0] flags_in,
  input wire [7:0] mem_rd_data,
  // watched outputs
  input wire mem_rd_en_q,
  input wire mem_wr_en_q,
  input wire [11:0] mem_addr_q,
  input wire [7:0] mem_wr_data_q,
  input wire ilo_mode_q,
  input wire [7:0] wreg_q,
  input wire [4:0] flags_q,
  input wire flags_wr_q,
  input wire pc_load_q,
  input wire flush_q,
  input wire busy_q,
  input wire illegal_q,
  input wire [1:0] phase_out_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // taken branch: four no-op clocks, then released
  sequence nop_cycle;
    flush_q [*4] ##1 !flush_q;
  endsequence
  // result lands two clocks after the read pulse
  sequence result_slot;
    ##2 (mem_wr_en_q || flags_wr_q);
  endsequence
  chk_bank_addr: assert property (mem_rd_en_q && instr[8] |-> mem_addr_q == {bank_select_register, instr[7:0]})
    else $error("bank address wrong");
  chk_access_addr: assert property (mem_rd_en_q && !instr[8] |->
    mem_addr_q == {(instr[7:0] > 8'h5F) ? 4'hF : 4'h0, instr[7:0]}) else $error("access address wrong");
  chk_indexed_mode: assert property (mem_rd_en_q |-> ilo_mode_q == (!instr[8] && ext_set_en && instr[7:0] <= 8'h5F))
    else $error("indexed mode wrong");
  chk_quarter_order: assert property (mem_rd_en_q |-> result_slot) else $error("write not two clocks after read");
  chk_and_file: assert property (mem_wr_en_q && $past(instr[15:10]) == 6'h05 |->
    $past(instr[9]) && flags_wr_q && mem_wr_data_q == ($past(mem_rd_data, 2) & wreg_q)) else $error("and to file wrong");
  chk_and_wreg: assert property (flags_wr_q && !mem_wr_en_q |->
    !$past(instr[9]) && wreg_q == ($past(mem_rd_data, 2) & $past(wreg_q))) else $error("and to wreg wrong");
  chk_flag_values: assert property (flags_wr_q |-> flags_q[2] == ((mem_wr_en_q ? mem_wr_data_q : wreg_q) == 8'h00)
    && flags_q[4] == (mem_wr_en_q ? mem_wr_data_q[7] : wreg_q[7])) else $error("zero or negative wrong");
  chk_flags_kept: assert property (flags_wr_q |-> {flags_q[3], flags_q[1:0]} == $past({flags_in[3], flags_in[1:0]}))
    else $error("other flags changed");
  chk_clear_bit: assert property (mem_wr_en_q && $past(instr[15:12]) == 4'h9 |-> !flags_wr_q &&
    mem_wr_data_q == ($past(mem_rd_data, 2) & ~(8'h01 << $past(instr[11:9])))) else $error("bit clear wrong");
  chk_taken_nop: assert property (pc_load_q |-> !flags_wr_q ##0 nop_cycle) else $error("no-op cycle wrong");
  chk_phase_wrap: assert property (phase_out_q == 2'h3 |=> phase_out_q == 2'h0)
    else $error("phase does not wrap after q4");
  chk_illegal_quiet: assert property (illegal_q |-> !mem_wr_en_q && !flags_wr_q && !pc_load_q && busy_q)
    else $error("unhandled word caused an action");
endmodule

// ===== verif/abbe_mem_model.sv
/* data memory model facing the block.
   assumes reads are answered in the same clock as the read pulse. */
`timescale 1ns/1ps
module abbe_mem_model (
  // clock
  input wire ref_clk,
  // memory side
  input wire mem_rd_en_q,
  input wire mem_wr_en_q,
  input wire [11:0] mem_addr_q,
  input wire [7:0] mem_wr_data_q,
  output wire [7:0] mem_rd_data
);
  logic [7:0] ram [0:4095]; // file bytes
  logic [7:0] junk_q = 8'h5A; // idle bus pattern
  // preset contents from the address
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'h3C ^ i[7:0] ^ {i[11:8], 4'h0};
  // store writes, toggle the idle pattern every clock
  always @(posedge ref_clk) begin
    junk_q <= ~junk_q;
    if (mem_wr_en_q) ram[mem_addr_q] <= mem_wr_data_q;
  end
  // data only while read is asserted
  assign mem_rd_data = mem_rd_en_q ? ram[mem_addr_q] : junk_q;
endmodule

// ===== verif/tb_top.sv
/* bench for the execution block: file ops and branches with a scoreboard.
   assumes the memory model and the checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected at %0t: %h", $time, a); end end
module tb_top;
  // driven inputs
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic ext_set_en = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [20:0] pc_cur = 21'h000000;
  logic [3:0] bank_select_register = 4'h0;
  logic [4:0] flags_in = 5'h00;
  // block outputs
  wire [7:0] mem_rd_data, mem_wr_data_q, wreg_q;
  wire [11:0] mem_addr_q;
  wire [4:0] flags_q;
  wire [20:0] pc_target_q;
  wire mem_rd_en_q, mem_wr_en_q, flags_wr_q, pc_load_q;
  wire busy_q, illegal_q;
  // scoreboard state
  logic [56:0] exp_q [$];
  logic [56:0] got, want;
  logic [7:0] shadow [0:4095];
  logic [7:0] w = 8'h00;
  logic [7:0] branch_op [0:4] = '{8'hE2, 8'hE3, 8'h6E, 8'hE7, 8'hE5};
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  abbe_exec #(.PC_W(21)) i_abbe_exec (.ref_clk, .rst_b, .instr_valid, .instr, .pc_cur, .ext_set_en,
    .bank_select_register, .flags_in, .mem_rd_data, .mem_rd_en_q, .mem_wr_en_q, .mem_addr_q, .mem_wr_data_q,
    .ilo_mode_q(), .wreg_q, .flags_q, .flags_wr_q, .pc_load_q, .pc_target_q, .flush_q(), .busy_q,
    .phase_out_q(), .illegal_q);
  abbe_mem_model i_abbe_mem_model (.ref_clk, .mem_rd_en_q, .mem_wr_en_q, .mem_addr_q, .mem_wr_data_q, .mem_rd_data);
  always #5 ref_clk = ~ref_clk;
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // monitor: each result event against the oldest note
  always @(negedge ref_clk) begin
    if (rst_b && (mem_wr_en_q || flags_wr_q || pc_load_q)) begin
      got = {mem_wr_en_q, flags_wr_q, pc_load_q, mem_wr_en_q ? {mem_addr_q, mem_wr_data_q} : 20'h00000,
        flags_wr_q ? flags_q : 5'h00, pc_load_q ? pc_target_q : 21'h000000, wreg_q};
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 57'h0;
      `CHK(got, want)
    end
  end
  // present one word for n clocks, noting its result
  task automatic run(input logic [15:0] iw, input int n, input logic push, input logic [56:0] e);
    if (push) exp_q.push_back(e);
    instr = iw;
    repeat (n) @(negedge ref_clk);
  endtask
  // counts and verdict
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin : main
    logic [7:0] f, r, off;
    logic [11:0] addr;
    logic a, d, t;
    logic [4:0] fl;
    void'($urandom(23541));
    for (int i = 0; i < 4096; i++) shadow[i] = 8'h3C ^ i[7:0] ^ {i[11:8], 4'h0};
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    instr_valid = 1'b1;
    // and with file, then every bit index of bit clear
    for (int k = 0; k < 32; k++) begin
      f = 8'($urandom);
      a = 1'($urandom);
      d = 1'($urandom);
      bank_select_register = 4'($urandom);
      ext_set_en = 1'($urandom);
      flags_in = 5'($urandom);
      if (k[3:0] < 4) begin
        a = 1'b0;
        ext_set_en = 1'b1;
        f = 8'h5E + 8'(k[1:0]);
      end
      addr = a ? {bank_select_register, f} : {(f > 8'h5F) ? 4'hF : 4'h0, f};
      if (k < 16) begin
        r = w & shadow[addr];
        fl = {r[7], flags_in[3], r == 8'h00, flags_in[1:0]};
        if (!d) w = r;
        else shadow[addr] = r;
        run({6'h05, d, a, f}, 4, 1'b1, {d, 2'b10, d ? {addr, r} : 20'h00000, fl, 21'h000000, w});
      end else begin
        r = shadow[addr] & ~(8'h01 << k[2:0]);
        shadow[addr] = r;
        run({4'h9, k[2:0], a, f}, 4, 1'b1, {3'b100, addr, r, 5'h00, 21'h000000, w});
      end
    end
    $display("file operations done");
    // each branch taken and not, both offset extremes
    for (int k = 0; k < 20; k++) begin
      off = k[1] ? 8'h7F : 8'h80;
      pc_cur = {20'($urandom), 1'b0};
      flags_in = {5{k[0]}} ^ (5'($urandom) & 5'h06);
      fl = flags_in;
      t = (k < 4) ? fl[0] : (k < 8) ? !fl[0] : (k < 12) ? fl[4] : (k < 16) ? !fl[4] : !fl[3];
      run({branch_op[k / 4], off}, t ? 8 : 4, t, {3'b001, 20'h00000, 5'h00, pc_cur + 21'h000002 + {{12{off[7]}}, off, 1'b0}, w});
    end
    $display("branches done");
    // unhandled word is flagged, then a word without valid is ignored
    run(16'hFFFF, 4, 1'b0, 57'h0);
    `CHK(illegal_q, 1'b1)
    instr_valid = 1'b0;
    run({6'h05, 1'b1, 1'b1, 8'h10}, 4, 1'b0, 57'h0);
    `CHK(busy_q, 1'b0)
    `CHK(illegal_q, 1'b0)
    $display("idle and unhandled done");
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule
bind abbe_exec abbe_exec_props i_abbe_exec_props (.ref_clk, .rst_b, .instr, .ext_set_en, .bank_select_register,
  .flags_in, .mem_rd_data, .mem_rd_en_q, .mem_wr_en_q, .mem_addr_q, .mem_wr_data_q, .ilo_mode_q, .wreg_q, .flags_q,
  .flags_wr_q, .pc_load_q, .flush_q, .busy_q, .illegal_q, .phase_out_q);
